/* File: verilog/dmarm_pkg.sv */
// package: offsets, field layout, reset values and carriers for the map block
package dmarm_pkg;
   // ==========================================================
   // register map (memory-mapped config region byte offsets)
   localparam logic [11:0] DMARM_MAP_OFFSET = 12'hd84;
   localparam logic [11:0] DMARM_PG0_OFFSET = 12'hd86;
   localparam logic [11:0] DMARM_PG1_OFFSET = 12'hd87;
   localparam logic [11:0] DMARM_PG2_OFFSET = 12'hd88;
   // ==========================================================
   // field positions in the serial request channel map
   localparam int DMARM_P2TX_LSB = 12;
   localparam int DMARM_P1TX_LSB = 8;
   localparam int DMARM_P2RX_LSB = 4;
   localparam int DMARM_P1RX_LSB = 0;
   localparam int DMARM_SEL_W    = 4;
   localparam int DMARM_PAGE_W   = 4;
   // ==========================================================
   // reset values
   localparam logic [15:0] DMARM_MAP_RESET  = 16'h0000;
   localparam logic [7:0]  DMARM_PAGE_RESET = 8'h00;
   // ==========================================================
   // serial request sources, in order p1rx, p2rx, p1tx, p2tx
   typedef struct packed {
      logic port2_tx;
      logic port1_tx;
      logic port2_rx;
      logic port1_rx;
   } dmarm_serial_t;
   // register access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } dmarm_reg_req_t;
endpackage : dmarm_pkg

/* File: verilog/dmarm_request_map.sv */
// serial request channel map and page extensions for channels 0 to 2
// ==========================================================
// Operation
// [RULE1] map bits 15..12 pick channel 0..3 for port 2 transmit pair
// [RULE2] map bits 11..8 pick channel 0..3 for port 1 transmit pair
// [RULE3] map bits 7..4 pick channel 0..3 for port 2 receive pair
// [RULE4] map bits 3..0 pick channel 0..3 for port 1 receive pair
// [RULE5] any other field code leaves that pair unconnected
// [RULE6] request and acknowledge of a pair go to one channel
// [RULE7] page extension bits 3..0 give address bits 27..24, channels 0..2
// [RULE8] software writes zero to reserved page extension bits 7..4
// [RULE9] address is page extension, page register and address register
// [RULE10] page extension bits hold steady through a transfer
// [RULE11] channels 0..2 have no enhanced mode
// [RULE12] mapped-device select ignored while channel serves a serial port
// [RULE13] only enhanced channels step extension on 16 MB crossing
// [RULE14] unconnected pair: acknowledge held low, request ignored
module dmarm_request_map
   import dmarm_pkg::*;
(
   input  wire logic                     clk_in,
   input  wire logic                     reset_n_in,
   input  wire dmarm_pkg::dmarm_reg_req_t reg_req_in,
   output logic [15:0]                   reg_rdata_out,
   input  wire dmarm_pkg::dmarm_serial_t serial_request_in,
   output dmarm_pkg::dmarm_serial_t      serial_acknowledge_out,
   input  wire logic [3:0]               channel_acknowledge_in,
   output logic [3:0]                    channel_request_out,
   input  wire logic [3:0]               memory_mapped_device_select_in,
   output logic [3:0]                    memory_mapped_effective_out,
   input  wire logic [23:0]              ch0_low_address_in,
   input  wire logic [23:0]              ch1_low_address_in,
   input  wire logic [23:0]              ch2_low_address_in,
   output logic [27:0]                   ch0_address_out,
   output logic [27:0]                   ch1_address_out,
   output logic [27:0]                   ch2_address_out
);
   import dmarm_pkg::*;

   logic [15:0] serial_request_channel_map;
   logic [7:0]  channel0_page_extension;
   logic [7:0]  channel1_page_extension;
   logic [7:0]  channel2_page_extension;
   logic [3:0]  sel      [4];
   logic [3:0]  next_req;
   logic [3:0]  next_ack;
   logic [3:0]  served;
   logic [3:0]  page_bits [3];
   logic [23:0] low_bits  [3];
   logic [27:0] full_addr [3];

   // ==========================================================
   // limits a user must know
   // several sources on one channel share it: requests are ORed and
   // every such source sees the same channel acknowledge
   // crossbar and address outputs lag their inputs by one clock
   // reserved page bits are stored and read back, never used as address
   // map reset value sends all four pairs to channel 0

   // ==========================================================
   // register writes; page fields change only by software writes
   // map register, written as a whole word
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         serial_request_channel_map <= DMARM_MAP_RESET;
      end else if (reg_req_in.wr && reg_req_in.addr == DMARM_MAP_OFFSET) begin
         serial_request_channel_map <= reg_req_in.wdata;
      end
   end

   // channel 0 page extension, reserved bits kept as written [RULE8]
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel0_page_extension <= DMARM_PAGE_RESET;
      end else if (reg_req_in.wr && reg_req_in.addr == DMARM_PG0_OFFSET) begin
         channel0_page_extension <= reg_req_in.wdata[7:0];
      end
   end

   // channel 1 page extension
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel1_page_extension <= DMARM_PAGE_RESET;
      end else if (reg_req_in.wr && reg_req_in.addr == DMARM_PG1_OFFSET) begin
         channel1_page_extension <= reg_req_in.wdata[7:0];
      end
   end

   // channel 2 page extension
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel2_page_extension <= DMARM_PAGE_RESET;
      end else if (reg_req_in.wr && reg_req_in.addr == DMARM_PG2_OFFSET) begin
         channel2_page_extension <= reg_req_in.wdata[7:0];
      end
   end

   // ==========================================================
   // register reads; unmapped offsets read zero
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            DMARM_MAP_OFFSET: reg_rdata_out <= serial_request_channel_map;
            DMARM_PG0_OFFSET:
               reg_rdata_out <= {8'h00, channel0_page_extension};
            DMARM_PG1_OFFSET:
               reg_rdata_out <= {8'h00, channel1_page_extension};
            DMARM_PG2_OFFSET:
               reg_rdata_out <= {8'h00, channel2_page_extension};
            default:          reg_rdata_out <= 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // field extraction, index = source bit of the serial carrier
   // 0 port 1 rx, 1 port 2 rx, 2 port 1 tx, 3 port 2 tx
   for (genvar g = 0; g < 4; g++) begin : g_field
      // field position of this source
      localparam int FIELD_LSB = (g == 0) ? DMARM_P1RX_LSB :
                                 (g == 1) ? DMARM_P2RX_LSB :
                                 (g == 2) ? DMARM_P1TX_LSB :
                                            DMARM_P2TX_LSB;
      // [RULE1] [RULE2] [RULE3] [RULE4]
      assign sel[g] = serial_request_channel_map[FIELD_LSB +: DMARM_SEL_W];
   end

   // ==========================================================
   // crossbar: request to channel, channel acknowledge back to source
   // request side: OR of every connected source per channel
   always_comb begin
      next_req = 4'h0;
      for (int s = 0; s < 4; s++) begin
         // codes 0000..0011 connect, all else unconnected [RULE5] [RULE14]
         if (sel[s][3:2] == 2'b00) begin
            next_req[sel[s][1:0]] = next_req[sel[s][1:0]]
                                    | serial_request_in[s];
         end
      end
   end

   // acknowledge side, same field as the request [RULE6]
   always_comb begin
      next_ack = 4'h0;
      served   = 4'h0;
      for (int s = 0; s < 4; s++) begin
         if (sel[s][3:2] == 2'b00) begin
            next_ack[s]         = channel_acknowledge_in[sel[s][1:0]];
            served[sel[s][1:0]] = 1'b1;
         end else begin
            next_ack[s] = 1'b0; // unconnected, never acknowledged [RULE14]
         end
      end
   end

   // registered channel requests
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel_request_out <= 4'h0;
      end else begin
         channel_request_out <= next_req;
      end
   end

   // registered serial acknowledges
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         serial_acknowledge_out <= '0;
      end else begin
         serial_acknowledge_out <= next_ack; // [RULE14]
      end
   end

   // mapped-device select masked on serially served channels
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         memory_mapped_effective_out <= 4'h0;
      end else begin
         memory_mapped_effective_out <=
            memory_mapped_device_select_in & ~served; // [RULE12]
      end
   end

   // ==========================================================
   // full addresses; extension is a static register field, no stepping
   // per-channel sources; reserved bits 7..4 never reach the address
   assign page_bits[0] = channel0_page_extension[DMARM_PAGE_W-1:0]; // [RULE7]
   assign page_bits[1] = channel1_page_extension[DMARM_PAGE_W-1:0];
   assign page_bits[2] = channel2_page_extension[DMARM_PAGE_W-1:0];
   assign low_bits[0]  = ch0_low_address_in;
   assign low_bits[1]  = ch1_low_address_in;
   assign low_bits[2]  = ch2_low_address_in;

   // one address register per channel, no enhanced-mode stepping
   for (genvar c = 0; c < 3; c++) begin : g_addr
      always_ff @(posedge clk_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            full_addr[c] <= 28'h0000000;
         end else begin
            // [RULE9] [RULE10] [RULE11] [RULE13]
            full_addr[c] <= {page_bits[c], low_bits[c]};
         end
      end
   end

   // outputs are the address registers themselves
   assign ch0_address_out = full_addr[0];
   assign ch1_address_out = full_addr[1];
   assign ch2_address_out = full_addr[2];
endmodule : dmarm_request_map

/* File: verification/dmarm_serial_model.sv */
// serial port request source model
module dmarm_serial_model
   import dmarm_pkg::*;
(
   input  wire logic                     clk_in,
   input  wire logic                     reset_n_in,
   input  wire dmarm_pkg::dmarm_serial_t want_in,
   output dmarm_pkg::dmarm_serial_t      req_out
);
   // request levels held while a port wants service
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) req_out <= '0;
      else req_out <= want_in;
   end
endmodule : dmarm_serial_model

/* File: verification/dmarm_request_map_assertions.sv */
// port checks for the request map block
module dmarm_request_map_assertions
   import dmarm_pkg::*;
(
   input wire logic                      clk_in,
   input wire logic                      reset_n_in,
   input wire dmarm_pkg::dmarm_reg_req_t reg_req_in,
   input wire logic [15:0]               reg_rdata_out,
   input wire dmarm_pkg::dmarm_serial_t  serial_request_in,
   input wire dmarm_pkg::dmarm_serial_t  serial_acknowledge_out,
   input wire logic [3:0]                channel_acknowledge_in,
   input wire logic [3:0]                channel_request_out,
   input wire logic [3:0]                memory_mapped_effective_out,
   input wire logic [23:0]               ch0_low_address_in,
   input wire logic [27:0]               ch0_address_out,
   input wire logic [27:0]               ch1_address_out,
   input wire logic [27:0]               ch2_address_out
);
   logic [15:0] m; // shadow of the channel map
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // ==========================================================
   // shadow follows map writes
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) m <= 16'h0000;
      else if (reg_req_in.wr && reg_req_in.addr == DMARM_MAP_OFFSET)
         m <= reg_req_in.wdata;
   end
   map_readback_a: assert property (reg_req_in.rd &&
      reg_req_in.addr == DMARM_MAP_OFFSET |=> reg_rdata_out == $past(m))
      else $error("map read data wrong");
   low_addr_a: assert property ($past(reset_n_in, 2) |->
      ch0_address_out[23:0] == $past(ch0_low_address_in))
      else $error("low address bits wrong");
   page_hold_a: assert property (!$past(reg_req_in.wr, 2) |->
      $stable({ch0_address_out[27:24], ch1_address_out[27:24],
               ch2_address_out[27:24]}))
      else $error("page extension moved");
   p1rx_route_a: assert property (serial_request_in.port1_rx &&
      m[3:0] < 4 |=> channel_request_out[$past(m[1:0])])
      else $error("port 1 receive request not routed");
   p2tx_route_a: assert property (serial_request_in.port2_tx &&
      m[15:12] < 4 |=> channel_request_out[$past(m[13:12])])
      else $error("port 2 transmit request not routed");
   unconn_ack_a: assert property (m[3:0] > 4'h3 |=>
      !serial_acknowledge_out.port1_rx)
      else $error("unconnected pair acknowledged");
   ack_pair_a: assert property (m[3:0] < 4 &&
      channel_acknowledge_in[m[1:0]] |=> serial_acknowledge_out.port1_rx)
      else $error("acknowledge not paired");
   mmio_mask_a: assert property (m[3:0] < 4 |=>
      !memory_mapped_effective_out[$past(m[1:0])])
      else $error("mapped select not masked");
endmodule : dmarm_request_map_assertions
bind dmarm_request_map dmarm_request_map_assertions
   i_dmarm_request_map_assertions (.*);

/* File: verification/dmarm_request_map_tb_top.sv */
// testbench for the serial request map and page extensions
module dmarm_request_map_tb_top import dmarm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic           clk_in = 1'b0, reset_n_in = 1'b0;
   dmarm_reg_req_t req = '0;
   dmarm_serial_t  want = '0, sreq, sack;
   logic [3:0]     ch_ack = 4'h0, ch_req, mm_eff;
   logic [15:0]    rdata;
   logic [27:0]    a[3];
   logic [23:0]    lo[3] = '{24'h123456, 24'habcdef, 24'h0f0f0f};
   logic [11:0]    ofs[5] = '{DMARM_MAP_OFFSET, DMARM_PG0_OFFSET,
                      DMARM_PG1_OFFSET, DMARM_PG2_OFFSET, 12'hd85};
   int             fails = 0, compares = 0;
   initial forever #50 clk_in = ~clk_in;
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [27:0] s, e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic reg_access(input logic w, input logic [11:0] ad,
                             input logic [15:0] d);
      @(posedge clk_in);
      req <= '{wr: w, rd: !w, addr: ad, wdata: d};
      @(posedge clk_in);
      req <= '0;
      #1;
   endtask : reg_access
   task automatic complete_run;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   dmarm_serial_model i_dmarm_serial_model (.clk_in, .reset_n_in,
      .want_in(want), .req_out(sreq));
   dmarm_request_map i_dmarm_request_map (.clk_in, .reset_n_in,
      .reg_req_in(req), .reg_rdata_out(rdata), .serial_request_in(sreq),
      .serial_acknowledge_out(sack), .channel_acknowledge_in(ch_ack),
      .channel_request_out(ch_req), .memory_mapped_device_select_in(4'hf),
      .memory_mapped_effective_out(mm_eff), .ch0_low_address_in(lo[0]),
      .ch1_low_address_in(lo[1]), .ch2_low_address_in(lo[2]),
      .ch0_address_out(a[0]), .ch1_address_out(a[1]),
      .ch2_address_out(a[2]));
   // ==========================================================
   // reset values, page extensions, then map codes 0 to 4 per field
   initial begin
      repeat (10) @(posedge clk_in);
      reset_n_in <= 1'b1;
      foreach (ofs[i]) begin
         reg_access(1'b0, ofs[i], 16'h0000);
         chk(rdata, 28'h0);
      end
      for (int i = 0; i < 3; i++) begin
         reg_access(1'b1, ofs[i + 1], 16'(10 + i));
         reg_access(1'b0, ofs[i + 1], 16'h0000);
         chk(rdata, 28'(10 + i));
         chk(a[i], {4'(10 + i), lo[i]});
      end
      for (int f = 0; f < 4; f++) begin
         for (int c = 0; c < 5; c++) begin
            reg_access(1'b1, ofs[0], ~(16'hf << 4 * f) | 16'(c << 4 * f));
            want <= 4'(1 << f);
            ch_ack <= c < 4 ? 4'(1 << c) : 4'hf;
            repeat (3) @(posedge clk_in);
            #1;
            chk(ch_req, c < 4 ? 28'(1 << c) : 28'h0);
            chk(sack, c < 4 ? 28'(1 << f) : 28'h0);
            chk(mm_eff, c < 4 ? 28'(~(1 << c) & 15) : 28'hf);
         end
      end
      for (int i = 0; i < 3; i++) chk(a[i], {4'(10 + i), lo[i]});
      complete_run();
   end
endmodule : dmarm_request_map_tb_top
